// File: hw/odu_oh_engine.sv
// path delay marker engine, status coding and tandem overhead layout
// assumes frame and overhead position inputs are synchronous to clk
//
// Our own choices: strobed register access and the register addresses.
module odu_oh_engine
  import odu_oh_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        ce,
  // register port
  input  wire logic [3:0]  regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [31:0] regRdata,
  // frame timing and received overhead
  input  wire logic        frameStart,
  input  wire logic [7:0]  multiframe,
  input  wire rx_oh_t      rxOh,
  // overhead position being built
  input  wire logic [1:0]  ohRow,
  input  wire logic [3:0]  ohCol,
  input  wire logic [7:0]  ohInstance,
  // transmitted overhead
  output logic [2:0]       txPathStatus,
  output logic             txPathMarker,
  output logic [5:0]       txTandemMarker,
  output logic [2:0]       txTandemStatus [6],
  output logic [11:0]      txPathReserved,
  output fld_t             ohField,
  output logic             traceStart,
  output logic [5:0]       traceIndex,
  output logic             traceDiscovery,
  // receive indications
  output maint_t           rxMaint,
  output logic             rxTandemUndefined
);

  ////////////////////////////////////////////////////////////////////////
  // helper functions

  // classify a received three-bit status code
  function automatic maint_t decode_status(input logic [2:0] code, input logic multi);
    case (code)
      `STAT_LOCKED: decode_status = MS_LOCKED;
      `STAT_OPEN:   decode_status = multi ? MS_NONE : MS_OPEN;
      `STAT_ALARM:  decode_status = MS_ALARM;
      default:      decode_status = MS_NONE;
    endcase
  endfunction

  // saturating frame counter step
  function automatic logic [15:0] sat_add(input logic [15:0] a, input logic [15:0] b);
    logic [16:0] s;
    s = {1'b0, a} + {1'b0, b};
    sat_add = s[16] ? `DELAY_MAX : s[15:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // control registers

  logic       startReq;
  logic       delayEnable;
  logic       multiLane;
  logic       discovery6;
  logic [2:0] maxLevels;
  logic [5:0] tandemMarkerCfg;
  logic [5:0] overlapMask;
  logic [1:0] tandemMaint [6];
  dm_state_t  dmState;

  wire wrCtrl   = ce && regWr && regAddr == `REG_CTRL;
  wire wrTandem = ce && regWr && regAddr == `REG_TANDEM;

  // control write; the start bit is a request that the engine consumes
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      delayEnable <= 1'b1;
      multiLane   <= 1'b0;
      discovery6  <= 1'b0;
      maxLevels   <= 3'h3;
    end else if (wrCtrl) begin
      delayEnable <= regWdata[`CTRL_DMEN_BIT];
      multiLane   <= regWdata[`CTRL_MULTI_BIT];
      discovery6  <= regWdata[`CTRL_DISC_BIT];
      // more than six levels cannot exist, so larger writes clamp
      maxLevels   <= (regWdata[`CTRL_MAXL_LSB +: 3] > `TANDEM_LEVELS) ?
                     `TANDEM_LEVELS : regWdata[`CTRL_MAXL_LSB +: 3];
    end
  end

  // start request: a new write wins over the consumption
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      startReq <= 1'b0;
    end else if (wrCtrl && regWdata[`CTRL_START_BIT] && delayEnable) begin
      startReq <= 1'b1;
    end else if (ce && frameStart && dmState == DM_IDLE) begin
      startReq <= 1'b0;
    end
  end

  // tandem settings: markers, overlap mask, per-level maintenance request
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tandemMarkerCfg <= 6'h00;
      overlapMask     <= 6'h00;
      for (int i = 0; i < 6; i++) tandemMaint[i] <= 2'h0;
    end else if (wrTandem) begin
      tandemMarkerCfg <= regWdata[`TAND_MARK_LSB +: 6];
      overlapMask     <= regWdata[`TAND_OVL_LSB +: 6];
      for (int i = 0; i < 6; i++) tandemMaint[i] <= regWdata[`TAND_MAINT_LSB + 2*i +: 2];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // path delay measurement

  logic       pathMarker;
  logic       rxMarkerPrev;
  logic [2:0] persistCnt;
  logic [15:0] frameCnt;
  logic [15:0] delayResult;
  logic       delayValid;
  logic       delayInvalid;

  wire rxBack   = rxOh.pathMarker == pathMarker;
  wire rxChange = rxOh.pathMarker != rxMarkerPrev;

  // previous received marker, for transition detection
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) rxMarkerPrev <= 1'b0;
    else if (ce && frameStart) rxMarkerPrev <= rxOh.pathMarker;
  end

  // measurement sequence; persistence frames are held apart from the count
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dmState      <= DM_IDLE;
      pathMarker   <= 1'b0;
      persistCnt   <= 3'h0;
      frameCnt     <= 16'h0000;
      delayResult  <= 16'h0000;
      delayValid   <= 1'b0;
      delayInvalid <= 1'b0;
    end else if (ce && frameStart) begin
      case (dmState)
        DM_IDLE: begin
          if (startReq) begin
            pathMarker   <= ~pathMarker;
            frameCnt     <= 16'h0000;
            delayValid   <= 1'b0;
            delayInvalid <= 1'b0;
            dmState      <= DM_WAIT;
          end
        end
        DM_WAIT: begin
          if (frameCnt == `DELAY_MAX) begin
            delayInvalid <= 1'b1;
            delayResult  <= `DELAY_MAX;
            dmState      <= DM_IDLE;
          end else if (rxBack && rxChange) begin
            persistCnt <= 3'h1;
            dmState    <= DM_CONFIRM;
          end else begin
            frameCnt <= sat_add(frameCnt, 16'h0001);
          end
        end
        DM_CONFIRM: begin
          if (!rxBack) begin
            // a bit error imitated the edge: those frames were real delay
            frameCnt <= sat_add(frameCnt, {13'h0, persistCnt} + 16'h0001);
            dmState  <= DM_WAIT;
          end else if (persistCnt + 3'h1 >= `PERSIST_FRAMES) begin
            delayResult <= frameCnt;
            delayValid  <= 1'b1;
            dmState     <= DM_IDLE;
          end else begin
            persistCnt <= persistCnt + 3'h1;
          end
        end
        default: dmState <= DM_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // transmitted overhead bits

  // path status, marker, reserved bits and tandem delay byte
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      txPathStatus   <= `STAT_NORMAL;
      txPathMarker   <= 1'b0;
      txPathReserved <= 12'h000;
      txTandemMarker <= 6'h00;
    end else if (ce) begin
      txPathStatus   <= `STAT_NORMAL;
      txPathMarker   <= delayEnable ? pathMarker : 1'b0;
      txPathReserved <= 12'h000;
      for (int i = 0; i < 6; i++)
        txTandemMarker[i] <= (3'(i) < maxLevels) ? tandemMarkerCfg[i] : 1'b0;
    end
  end

  // tandem status; overlapped endpoints stay non-intrusive
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < 6; i++) txTandemStatus[i] <= `STAT_NOSRC;
    end else if (ce) begin
      for (int i = 0; i < 6; i++) begin
        if (3'(i) >= maxLevels)
          txTandemStatus[i] <= `STAT_NOSRC;
        else if (overlapMask[i])
          txTandemStatus[i] <= `STAT_INUSE;
        else if (tandemMaint[i] == 2'h1)
          txTandemStatus[i] <= `STAT_LOCKED;
        else if (tandemMaint[i] == 2'h2)
          txTandemStatus[i] <= `STAT_ALARM;
        else if (tandemMaint[i] == 2'h3 && !multiLane)
          txTandemStatus[i] <= `STAT_OPEN;
        else
          txTandemStatus[i] <= `STAT_INUSE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // overhead layout and trace alignment

  fld_t next_field;

  // map row/column to a field; row 2 cols 5-13 hold levels 3..1, row 3 cols 1-9 levels 6..4
  always_comb begin
    logic [3:0] off;
    off        = 4'h0;
    next_field = '{kind: FLD_OTHER, level: 3'h0, sub: 2'h0, resv: 1'b0};
    if (ohRow == 2'h2 && ohCol == 4'h3) begin
      next_field.kind = FLD_DELAYB;
    end else if (ohRow == 2'h2 && ohCol >= 4'h5 && ohCol <= 4'hd) begin
      off              = ohCol - 4'h5;
      next_field.kind  = FLD_TANDEM;
      next_field.level = 3'h3 - 3'(off / 4'h3);
      next_field.sub   = 2'(off % 4'h3);
    end else if (ohRow == 2'h3 && ohCol >= 4'h1 && ohCol <= 4'h9) begin
      off              = ohCol - 4'h1;
      next_field.kind  = FLD_TANDEM;
      next_field.level = 3'h6 - 3'(off / 4'h3);
      next_field.sub   = 2'(off % 4'h3);
    end else if (ohRow == 2'h3 && ohCol >= 4'ha && ohCol <= 4'hc) begin
      next_field.kind = FLD_PATH;
      next_field.sub  = 2'(ohCol - 4'ha);
    end
    // instance 1 carries full subfields; later lanes are partly reserved in multi-lane and FLD_OTHER in single-lane
    if (multiLane && ohInstance > 8'h01 && next_field.kind != FLD_OTHER
        && next_field.kind != FLD_DELAYB)
      next_field.resv = 1'b1;
    if (!multiLane && ohInstance > 8'h01)
      next_field.kind = FLD_OTHER;
  end

  // registered field, trace index and discovery select
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ohField        <= '{kind: FLD_OTHER, level: 3'h0, sub: 2'h0, resv: 1'b0};
      traceStart     <= 1'b0;
      traceIndex     <= 6'h00;
      traceDiscovery <= 1'b0;
    end else if (ce) begin
      ohField        <= next_field;
      traceIndex     <= multiframe[5:0];
      traceStart     <= (multiframe & `TRACE_PERIOD_MASK) == 8'h00;
      traceDiscovery <= discovery6 && next_field.level == 3'h6;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // receive indications

  // maintenance decode, and tandem content marked undefined under it
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rxMaint           <= MS_NONE;
      rxTandemUndefined <= 1'b0;
    end else if (ce && frameStart) begin
      rxMaint           <= decode_status(rxOh.pathStatus, multiLane);
      rxTandemUndefined <= decode_status(rxOh.pathStatus, multiLane) != MS_NONE;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register read

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      regRdata <= 32'h0000_0000;
    end else if (ce) begin
      regRdata <= 32'h0000_0000;
      if (regRd) begin
        case (regAddr)
          `REG_CTRL:   regRdata <= {25'h0, maxLevels, discovery6, multiLane,
                                    delayEnable, startReq};
          `REG_TANDEM: regRdata <= {4'h0, tandemMaint[5], tandemMaint[4], tandemMaint[3],
                                    tandemMaint[2], tandemMaint[1], tandemMaint[0],
                                    2'h0, overlapMask, 2'h0, tandemMarkerCfg};
          `REG_STATUS: regRdata <= {23'h0, rxMaint, dmState, delayInvalid, delayValid,
                                    pathMarker};
          `REG_DELAY:  regRdata <= {16'h0, delayResult};
          default:     regRdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // assertions

  sequence startFrame_s;
    ce && frameStart && dmState == DM_IDLE && startReq;
  endsequence

  marker_flip_a: assert property (@(posedge clk) disable iff (!resetn)
    startFrame_s |=> pathMarker != $past(pathMarker))
    else $error("marker did not invert at test start");

  marker_hold_a: assert property (@(posedge clk) disable iff (!resetn)
    !(ce && frameStart && dmState == DM_IDLE) |=> $stable(pathMarker))
    else $error("marker changed outside a test start");

  status_normal_a: assert property (@(posedge clk) disable iff (!resetn)
    ##1 txPathStatus == `STAT_NORMAL)
    else $error("path status not normal");

  marker_off_a: assert property (@(posedge clk) disable iff (!resetn)
    ce && !delayEnable |=> !txPathMarker)
    else $error("marker sent with delay support off");

  count_excl_a: assert property (@(posedge clk) disable iff (!resetn)
    dmState == DM_CONFIRM && ce && frameStart && rxBack
      && persistCnt + 3'h1 >= `PERSIST_FRAMES |=> delayResult == $past(frameCnt))
    else $error("persistence frames counted in delay");

  sat_invalid_a: assert property (@(posedge clk) disable iff (!resetn)
    dmState == DM_WAIT && ce && frameStart && frameCnt == `DELAY_MAX
      |=> delayInvalid && dmState == DM_IDLE)
    else $error("saturated count not flagged");

  overlap_quiet_a: assert property (@(posedge clk) disable iff (!resetn)
    ce && overlapMask[0] && maxLevels != 3'h0 |=> txTandemStatus[0] == `STAT_INUSE)
    else $error("overlapped endpoint sent maintenance");

  alarm_decode_a: assert property (@(posedge clk) disable iff (!resetn)
    ce && frameStart && rxOh.pathStatus == `STAT_ALARM |=> rxMaint == MS_ALARM
      && rxTandemUndefined)
    else $error("alarm code not decoded");

  trace_align_a: assert property (@(posedge clk) disable iff (!resetn)
    ce && multiframe == 8'h40 |=> traceStart && traceIndex == 6'h00)
    else $error("trace not aligned to multiframe");

endmodule

// File: hw/odu_oh_map.svh
// register offsets, field positions, reset values and frame counts of the overhead block
// assumes inclusion by bare name from the package, whose macros the design module uses
`ifndef ODU_OH_MAP_SVH
`define ODU_OH_MAP_SVH
// register byte offsets
`define REG_CTRL        4'h0
`define REG_TANDEM      4'h4
`define REG_STATUS      4'h8
`define REG_DELAY       4'hc
// control register fields
`define CTRL_START_BIT  0
`define CTRL_DMEN_BIT   1
`define CTRL_MULTI_BIT  2
`define CTRL_DISC_BIT   3
`define CTRL_MAXL_LSB   4
`define CTRL_RESET      8'h32
// tandem register fields
`define TAND_MARK_LSB   0
`define TAND_OVL_LSB    8
`define TAND_MAINT_LSB  16
// path and tandem status codes
`define STAT_NORMAL     3'h1
`define STAT_LOCKED     3'h5
`define STAT_OPEN       3'h6
`define STAT_ALARM      3'h7
`define STAT_NOSRC      3'h0
`define STAT_INUSE      3'h1
// frame counts, tandem level limit and trace period mask
`define PERSIST_FRAMES  3'h3
`define DELAY_MAX       16'hffff
`define TANDEM_LEVELS   3'h6
`define TRACE_PERIOD_MASK 8'h3f
`endif

// File: hw/odu_oh_pkg.sv
// types shared by the overhead block and its bench
// assumes odu_oh_map.svh sits beside it on the include path
package odu_oh_pkg;
  `include "odu_oh_map.svh"
  typedef enum logic [2:0] {
    DM_IDLE    = 3'b001,
    DM_WAIT    = 3'b010,
    DM_CONFIRM = 3'b100
  } dm_state_t;
  typedef enum logic [2:0] {
    MS_NONE   = 3'b000,
    MS_LOCKED = 3'b001,
    MS_OPEN   = 3'b010,
    MS_ALARM  = 3'b100
  } maint_t;
  typedef enum logic [2:0] {
    FLD_OTHER  = 3'h0,
    FLD_TANDEM = 3'h1,
    FLD_PATH   = 3'h2,
    FLD_DELAYB = 3'h3
  } fld_kind_t;
  // overhead byte classification for one row/column position
  typedef struct packed {
    fld_kind_t  kind;
    logic [2:0] level;   // tandem level 1..6, 0 outside the tandem byte positions
    logic [1:0] sub;     // byte within the three-byte field
    logic       resv;    // byte carries reserved content in this instance
  } fld_t;
  // received overhead sampled at a frame boundary
  typedef struct packed {
    logic [2:0] pathStatus;
    logic       pathMarker;
    logic [5:0] tandemMarker;
  } rx_oh_t;
endpackage

// File: testbench/odu_far_end.sv
// far-end path endpoint model: loops the path delay marker back after whole frames
// assumes frameStart pulses once per frame on clk and the bench picks the loop length
module odu_far_end
  import odu_oh_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // frame link
  input  wire logic       frameStart,
  input  wire logic       txMarker,
  output rx_oh_t          rxOh,
  // scenario controls
  input  wire logic [3:0] loopFrames,
  input  wire logic       glitch,
  input  wire logic [2:0] status,
  input  wire logic [5:0] tandemMarker
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] hist;
  ////////////////////////////////////////////////////////////////////////////////
  // capture each transmitted marker bit once per frame
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hist <= 16'h0000;
    end else if (frameStart) begin
      hist <= {hist[14:0], txMarker};
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // loop of at most 16 frames stays far inside 100 us; glitch fakes one bit error
  always_comb begin
    rxOh.pathStatus   = status;
    rxOh.pathMarker   = hist[loopFrames - 4'h1] ^ glitch;
    rxOh.tandemMarker = tandemMarker;
  end
endmodule

// File: testbench/odu_path_delay_and_tcm_overhead_tb.sv
// self-checking bench of the overhead engine against integer models of its behaviour
// assumes the engine header and package as given; frames are 8 clocks long
module odu_path_delay_and_tcm_overhead_tb
  import odu_oh_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
`define CHK(got, exp) begin numChecks++; if ((got) !== (exp)) begin nErrors++; \
  $display("[ERR] %0t got %0h exp %0h", $time, (got), (exp)); end end
  logic        clk, resetn, ce, regWr, regRd, frameStart, glitch;
  logic [3:0]  regAddr, ohCol, loopF;
  logic [31:0] regWdata, regRdata;
  logic [7:0]  multiframe, ohInstance;
  logic [1:0]  ohRow;
  logic [2:0]  txPathStatus, rxStat, fcnt;
  logic        txPathMarker, traceStart, traceDiscovery, rxTandemUndefined;
  logic [5:0]  txTandemMarker, traceIndex, rxTm;
  logic [2:0]  txTandemStatus [6];
  logic [11:0] txPathReserved;
  fld_t        ohField;
  maint_t      rxMaint;
  rx_oh_t      rxOh;
  int          nErrors, numChecks;
  integer      seed;
  ////////////////////////////////////////////////////////////////////////////////
  odu_oh_engine dut (.clk(clk), .resetn(resetn), .ce(ce), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .frameStart(frameStart), .multiframe(multiframe), .rxOh(rxOh), .ohRow(ohRow),
    .ohCol(ohCol), .ohInstance(ohInstance), .txPathStatus(txPathStatus),
    .txPathMarker(txPathMarker), .txTandemMarker(txTandemMarker),
    .txTandemStatus(txTandemStatus), .txPathReserved(txPathReserved), .ohField(ohField),
    .traceStart(traceStart), .traceIndex(traceIndex), .traceDiscovery(traceDiscovery),
    .rxMaint(rxMaint), .rxTandemUndefined(rxTandemUndefined));
  odu_far_end farEnd (.clk(clk), .resetn(resetn), .frameStart(frameStart),
    .txMarker(txPathMarker), .rxOh(rxOh), .loopFrames(loopF), .glitch(glitch),
    .status(rxStat), .tandemMarker(rxTm));
  ////////////////////////////////////////////////////////////////////////////////
  // clock and a frame pulse every eighth cycle
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // frame phase restarts with reset so the counter has a single driver
  always @(posedge clk) begin
    if (!resetn) begin
      fcnt       <= 3'h0;
      frameStart <= 1'b0;
    end else begin
      fcnt       <= fcnt + 3'h1;
      frameStart <= (fcnt == 3'h7);
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic completeRun();
    $display("checks %0d errors %0d", numChecks, nErrors);
    if (nErrors == 0 && numChecks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // bus cycles: strobe one cycle, read data taken the cycle after
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1 d = regRdata;
  endtask
  task automatic frames(input int n);
    repeat (n) @(posedge clk iff frameStart);
  endtask
  // one round trip with a loop of l frames; g > 0 fakes a returned bit at frame g+1
  task automatic measure(input int l, input int g);
    logic [31:0] d;
    logic        m0;
    loopF <= l[3:0];
    frames(l + 2);
    #1 m0 = txPathMarker;
    wr(`REG_CTRL, 32'h33);
    frames(1);
    repeat (2) @(posedge clk);
    #1 `CHK(txPathMarker, ~m0)
    for (int f = 1; f < l + 6; f++) begin
      frames(1);
      glitch <= (f == g);
    end
    // confirm frames never add to the count; frames spent on the faked edge are added back as delay
    rd(`REG_DELAY, d);
    `CHK(d[15:0], l[15:0])
    rd(`REG_STATUS, d);
    `CHK(d[2:0], {2'b01, ~m0})
    `CHK(txPathMarker, ~m0)
  endtask
  // overhead byte classification from the field layout
  function automatic fld_t expField(int r, int c, int inst, int multi);
    fld_t f;
    f = '{FLD_OTHER, 3'h0, 2'h0, 1'b0};
    if (multi == 0 && inst > 1) return f;
    f.resv = (inst > 1);
    if (r == 2 && c == 3) f.kind = FLD_DELAYB;
    if (r == 3 && c >= 10 && c <= 12) f.kind = FLD_PATH;
    if ((r == 2 && c >= 5 && c <= 13) || (r == 3 && c >= 1 && c <= 9)) begin
      f.kind = FLD_TANDEM;
      f.level = (r == 2) ? 3'(3 - (c - 5) / 3) : 3'(6 - (c - 1) / 3);
      f.sub = (r == 2) ? 2'((c - 5) % 3) : 2'((c - 1) % 3);
    end
    return f;
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  // watchdog far beyond the roughly 1100 cycles the sequence needs
  initial begin
    repeat (60000) @(posedge clk);
    nErrors++;
    completeRun();
  end
  initial begin
    logic [31:0] d;
    seed = 32'h1d62;
    {resetn, ce, regWr, regRd, glitch} = '0;
    {regAddr, regWdata, multiframe, ohRow, ohCol, ohInstance, rxTm} = '0;
    loopF = 4'h1;
    rxStat = 3'h1;
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    ce <= 1'b1;
    rd(`REG_CTRL, d);
    `CHK(d, 32'h32)
    rd(4'h2, d);
    `CHK(d, 32'h0)
    @(posedge clk);
    ce <= 1'b0;
    wr(`REG_CTRL, 32'h0);
    ce <= 1'b1;
    rd(`REG_CTRL, d);
    `CHK(d, 32'h32)
    measure(1, 0);
    measure(6, 2);
    measure(3, 1);
    wr(`REG_CTRL, 32'h31);
    frames(3);
    #1 `CHK(txPathMarker, 1'b0)
    // received status decode, single- then multi-lane
    for (int ml = 0; ml < 2; ml++) begin
      wr(`REG_CTRL, 32'h32 | (ml << 2));
      for (int c = 0; c < 8; c++) begin
        maint_t e;
        e = (c == 5) ? MS_LOCKED : (c == 7) ? MS_ALARM : MS_NONE;
        if (c == 6 && ml == 0) e = MS_OPEN;
        rxStat <= c[2:0];
        frames(2);
        #1 `CHK(rxMaint, e)
        `CHK(rxTandemUndefined, e != MS_NONE)
        rd(`REG_STATUS, d);
        `CHK(d[8:6], e)
      end
    end
    rxStat <= 3'h1;
    // tandem markers and status across every maximum level, 7 clamping to 6
    for (int t = 0; t < 8; t++) begin
      logic [5:0]  mk, ov;
      logic [11:0] rq;
      int          lv;
      lv = (t > 6) ? 6 : t;
      mk = 6'($random(seed));
      // the loop holds no protected domain, so overlap never needs protection forced
      ov = 6'($random(seed));
      rq = 12'($random(seed));
      wr(`REG_CTRL, 32'h02 | (t << 4));
      wr(`REG_TANDEM, {4'h0, rq, 2'h0, ov, 2'h0, mk});
      repeat (2) @(posedge clk);
      #1 `CHK(txTandemMarker, mk & 6'((1 << lv) - 1))
      for (int i = 0; i < 6; i++) begin
        logic [2:0] es;
        es = (rq[2*i +: 2] == 2'h1) ? 3'h5 : (rq[2*i +: 2] == 2'h2) ? 3'h7 : 3'h1;
        if (rq[2*i +: 2] == 2'h3) es = 3'h6;
        if (ov[i]) es = 3'h1;
        if (i >= lv) es = 3'h0;
        `CHK(txTandemStatus[i], es)
      end
      rd(`REG_CTRL, d);
      `CHK(d[6:4], lv[2:0])
    end
    // every overhead position, random instance, discovery on
    for (int ml = 0; ml < 2; ml++) begin
      wr(`REG_CTRL, 32'h3a | (ml << 2));
      for (int p = 0; p < 64; p++) begin
        fld_t e;
        int   inst;
        inst = 1 + (($random(seed) & 32'h7fffffff) % 3);
        e = expField(p / 16, p % 16, inst, ml);
        @(posedge clk);
        ohRow <= 2'(p / 16);
        ohCol <= 4'(p % 16);
        ohInstance <= 8'(inst);
        @(posedge clk);
        #1 `CHK(ohField.kind, e.kind)
        if (e.kind == FLD_TANDEM) `CHK(ohField, e)
        if (inst == 1) `CHK(traceDiscovery, e.kind == FLD_TANDEM && e.level == 3'h6)
        `CHK({txPathStatus, txPathReserved}, 15'h1000)
      end
    end
    // trace alignment over the four quarter starts and random positions
    for (int i = 0; i < 40; i++) begin
      logic [7:0] v;
      v = (i < 4) ? 8'(i * 64) : 8'($random(seed));
      @(posedge clk);
      multiframe <= v;
      @(posedge clk);
      #1 `CHK({traceStart, traceIndex}, {v[5:0] == 6'h0, v[5:0]})
    end
    completeRun();
  end
endmodule
